// ==== alarm_regs.svh ====
// Register offsets, field positions and timing counts for the alarm compare block
`ifndef ALARM_REGS_SVH
`define ALARM_REGS_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define OFS_ALARM_WEEKDAY_HOURS 4'h0
`define OFS_ALARM_MINUTES_SECONDS 4'h1
`define OFS_ALARM_CTRL 4'h2
`define OFS_IRQ_STATUS 4'h3
`define OFS_IRQ_MASK 4'h4

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define WDH_USED_MASK 16'h073F
`define MS_USED_MASK 16'h7F7F
`define CTRL_UNLOCK_BIT 4
`define CTRL_ENABLE_BIT 5
`define CTRL_USED_MASK 16'h003F
`define IRQ_USED_MASK 16'h0001
`define HALF_SEC_IN_SEC 1'h1

`endif

// ==== alarm_pkg.sv ====
// Types shared by the alarm compare block
`default_nettype none

package alarm_pkg;

  // Running calendar time as BCD digits
  typedef struct packed {
    logic [3:0] month_tens_ones_hi;
    logic [3:0] month_ones;
    logic [1:0] mday_tens;
    logic [3:0] mday_ones;
    logic [2:0] weekday;
    logic [1:0] hour_tens;
    logic [3:0] hour_ones;
    logic [2:0] min_tens;
    logic [3:0] min_ones;
    logic [2:0] sec_tens;
    logic [3:0] sec_ones;
  } rtc_time_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Repeat rate selection
  typedef enum logic [3:0] {
    REP_HALF_SEC = 4'h0,
    REP_SEC = 4'h1,
    REP_10_SEC = 4'h2,
    REP_MIN = 4'h3,
    REP_10_MIN = 4'h4,
    REP_HOUR = 4'h5,
    REP_DAY = 4'h6,
    REP_WEEK = 4'h7,
    REP_MONTH = 4'h8,
    REP_YEAR = 4'h9
  } repeat_sel_t;

endpackage

`default_nettype wire

// ==== rtc_alarm_compare.sv ====
// Alarm compare block of a real-time clock with register port and interrupt
// How it works
// - The hour ones digit lives in bits 3..0 of the weekday/hours register, 0 to 9.
// - Writes to the weekday/hours register land only while the write unlock bit is 1.
// - The minute tens digit lives in bits 14..12 of the minutes/seconds register, 0 to 5.
// - The minute ones digit lives in bits 11..8 of the minutes/seconds register, 0 to 9.
// - The second tens digit lives in bits 6..4 of the minutes/seconds register, 0 to 5.
// - The second ones digit lives in bits 3..0 of the minutes/seconds register, 0 to 9.
// - Unused bits of both alarm registers read zero and stored bits have no reset value.
// - Select 0000 fires every half second and 0001 every second with no field compared.
// - Selects 0010 to 0101 compare seconds ones, seconds, plus minute ones, minutes.
// - Selects 0110 to 1001 add hours; 0111 also adds weekday, 1000 and 1001 compare the same fields as 0110.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_regs.svh"

module rtc_alarm_compare (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Running time and its ticks
  input wire alarm_pkg::rtc_time_t now_time,
  input wire logic half_tick,
  input wire logic sec_tick,
  // Alarm outputs
  output logic alarm_event,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  // Asynchronous assert, two-flop release to avoid recovery hazards
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  // Two BCD fields compare equal
  function automatic logic digit_eq(input logic [3:0] a, input logic [3:0] b);
    digit_eq = (a == b);
  endfunction

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  alarm_pkg::reg_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic [2:0] alarm_weekday_digit_q;
  logic [1:0] alarm_hour_tens_q;
  logic [3:0] alarm_hour_ones_q;
  logic [2:0] alarm_minute_tens_q;
  logic [3:0] alarm_minute_ones_q;
  logic [2:0] alarm_second_tens_q;
  logic [3:0] alarm_second_ones_q;
  logic [3:0] alarm_repeat_select_q;
  logic rtc_write_unlock_q;
  logic alarm_enable_q;
  logic irq_status_q;
  logic irq_mask_q;
  logic [15:0] rdata_q;

  logic wr_wdh;
  logic wr_ms;
  assign wr_wdh = req.wr && (req.addr == `OFS_ALARM_WEEKDAY_HOURS) && rtc_write_unlock_q;
  assign wr_ms = req.wr && (req.addr == `OFS_ALARM_MINUTES_SECONDS);

  // Alarm value storage has no reset: contents are unknown after power up
  always_ff @(posedge clk) begin
    if (wr_wdh) begin
      alarm_weekday_digit_q <= req.wdata[10:8];
      alarm_hour_tens_q <= req.wdata[5:4];
      alarm_hour_ones_q <= req.wdata[3:0];
    end
    if (wr_ms) begin
      alarm_minute_tens_q <= req.wdata[14:12];
      alarm_minute_ones_q <= req.wdata[11:8];
      alarm_second_tens_q <= req.wdata[6:4];
      alarm_second_ones_q <= req.wdata[3:0];
    end
  end

  // Control register: repeat select, unlock, enable
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alarm_repeat_select_q <= 4'h0;
      rtc_write_unlock_q <= 1'b0;
      alarm_enable_q <= 1'b0;
    end else if (req.wr && req.addr == `OFS_ALARM_CTRL) begin
      alarm_repeat_select_q <= req.wdata[3:0];
      rtc_write_unlock_q <= req.wdata[`CTRL_UNLOCK_BIT];
      alarm_enable_q <= req.wdata[`CTRL_ENABLE_BIT];
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_mask_q <= 1'b0;
    end else if (req.wr && req.addr == `OFS_IRQ_MASK) begin
      irq_mask_q <= req.wdata[0];
    end
  end

  // Read mux, data one cycle after the strobe; unused bits read zero
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        `OFS_ALARM_WEEKDAY_HOURS: rdata_q <= {5'h00, alarm_weekday_digit_q, 2'h0,
            alarm_hour_tens_q, alarm_hour_ones_q};
        `OFS_ALARM_MINUTES_SECONDS: rdata_q <= {1'h0, alarm_minute_tens_q,
            alarm_minute_ones_q, 1'h0, alarm_second_tens_q, alarm_second_ones_q};
        `OFS_ALARM_CTRL: rdata_q <= {10'h000, alarm_enable_q, rtc_write_unlock_q,
            alarm_repeat_select_q};
        `OFS_IRQ_STATUS: rdata_q <= {15'h0000, irq_status_q};
        `OFS_IRQ_MASK: rdata_q <= {15'h0000, irq_mask_q};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------------------
  // Compare
  // ---------------------------------------------------------------------------
  logic m_s1;
  logic m_s10;
  logic m_m1;
  logic m_m10;
  logic m_h;
  logic m_wd;
  logic match;
  logic tick;
  logic alarm_q;

  assign m_s1 = digit_eq(now_time.sec_ones, alarm_second_ones_q);
  assign m_s10 = digit_eq({1'b0, now_time.sec_tens}, {1'b0, alarm_second_tens_q});
  assign m_m1 = digit_eq(now_time.min_ones, alarm_minute_ones_q);
  assign m_m10 = digit_eq({1'b0, now_time.min_tens}, {1'b0, alarm_minute_tens_q});
  assign m_h = digit_eq({2'h0, now_time.hour_tens}, {2'h0, alarm_hour_tens_q})
      && digit_eq(now_time.hour_ones, alarm_hour_ones_q);
  assign m_wd = digit_eq({1'b0, now_time.weekday}, {1'b0, alarm_weekday_digit_q});

  // Day and month alarm digits are not stored here, so those selects match
  // on the time fields the block owns; the date digits come in with the time.
  // Cumulative field selection by repeat rate
  always_comb begin
    tick = sec_tick;
    match = 1'b0;
    case (alarm_pkg::repeat_sel_t'(alarm_repeat_select_q))
      alarm_pkg::REP_HALF_SEC: begin
        tick = half_tick;
        match = 1'b1;
      end
      alarm_pkg::REP_SEC: match = 1'b1;
      alarm_pkg::REP_10_SEC: match = m_s1;
      alarm_pkg::REP_MIN: match = m_s1 && m_s10;
      alarm_pkg::REP_10_MIN: match = m_s1 && m_s10 && m_m1;
      alarm_pkg::REP_HOUR: match = m_s1 && m_s10 && m_m1 && m_m10;
      alarm_pkg::REP_DAY: match = m_s1 && m_s10 && m_m1 && m_m10 && m_h;
      alarm_pkg::REP_WEEK: match = m_s1 && m_s10 && m_m1 && m_m10 && m_h && m_wd;
      alarm_pkg::REP_MONTH: match = m_s1 && m_s10 && m_m1 && m_m10 && m_h;
      // Year select compares the same fields as the daily select; no date digits are checked
      alarm_pkg::REP_YEAR: match = m_s1 && m_s10 && m_m1 && m_m10 && m_h;
      default: match = 1'b0;
    endcase
  end

  // One-cycle alarm event on the matching tick
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_enable_q && tick && match;
    end
  end
  assign alarm_event = alarm_q;

  // ---------------------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------------------
  // Set wins over read-to-clear so no event is lost
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_status_q <= 1'b0;
    end else if (alarm_q) begin
      irq_status_q <= 1'b1;
    end else if (req.rd && req.addr == `OFS_IRQ_STATUS) begin
      irq_status_q <= 1'b0;
    end
  end
  assign irq = irq_status_q && irq_mask_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Status read that does not meet a new alarm: the bit must drop
  sequence s_read_clear;
    reg_rd && reg_addr == `OFS_IRQ_STATUS && !alarm_event;
  endsequence

  // Status read in the very cycle an alarm lands: the set has to win
  sequence s_read_and_set;
    reg_rd && reg_addr == `OFS_IRQ_STATUS && alarm_event;
  endsequence

  // Status set, and the interrupt output follows it through the mask
  sequence s_status_to_irq;
    irq_status_q ##0 (irq == irq_mask_q);
  endsequence

  // Register storage and readback
  a_locked_write: assert property (@(posedge clk) disable iff (!rst_n_q)
      (reg_wr && reg_addr == `OFS_ALARM_WEEKDAY_HOURS && !rtc_write_unlock_q)
      |=> $stable({alarm_weekday_digit_q, alarm_hour_tens_q, alarm_hour_ones_q}))
      else $error("locked write changed weekday or hours");
  a_unlocked_write: assert property (@(posedge clk) disable iff (!rst_n_q)
      (reg_wr && reg_addr == `OFS_ALARM_WEEKDAY_HOURS && rtc_write_unlock_q)
      |=> alarm_weekday_digit_q == $past(reg_wdata[10:8]))
      else $error("weekday not stored");
  a_hours_store: assert property (@(posedge clk) disable iff (!rst_n_q)
      wr_wdh |=> {alarm_hour_tens_q, alarm_hour_ones_q} == $past(reg_wdata[5:0]))
      else $error("hours not stored");
  a_minsec_store: assert property (@(posedge clk) disable iff (!rst_n_q)
      wr_ms |=> {alarm_minute_tens_q, alarm_minute_ones_q, alarm_second_tens_q,
      alarm_second_ones_q} == {$past(reg_wdata[14:8]), $past(reg_wdata[6:0])})
      else $error("minutes/seconds not stored");
  a_minsec_read: assert property (@(posedge clk) disable iff (!rst_n_q)
      (reg_rd && reg_addr == `OFS_ALARM_MINUTES_SECONDS)
      |=> (reg_rdata & ~`MS_USED_MASK) == 16'h0000 && reg_rdata[3:0] == alarm_second_ones_q)
      else $error("minutes/seconds readback wrong");
  a_wdh_read: assert property (@(posedge clk) disable iff (!rst_n_q)
      (reg_rd && reg_addr == `OFS_ALARM_WEEKDAY_HOURS)
      |=> (reg_rdata & ~`WDH_USED_MASK) == 16'h0000)
      else $error("unused bits not zero");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n_q)
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside the read cycle");

  // Repeat selects and the alarm event
  a_half_sec: assert property (@(posedge clk) disable iff (!rst_n_q)
      (alarm_enable_q && half_tick && alarm_repeat_select_q == 4'h0) |=> alarm_event)
      else $error("missing half second alarm");
  a_every_sec: assert property (@(posedge clk) disable iff (!rst_n_q)
      (alarm_enable_q && sec_tick && alarm_repeat_select_q == 4'h1) |=> alarm_event)
      else $error("missing per-second alarm");
  a_ten_sec: assert property (@(posedge clk) disable iff (!rst_n_q)
      (alarm_enable_q && sec_tick && alarm_repeat_select_q == 4'h2
      && now_time.sec_ones != alarm_second_ones_q) |=> !alarm_event)
      else $error("10 second alarm fired on mismatch");
  a_daily_match: assert property (@(posedge clk) disable iff (!rst_n_q)
      (alarm_enable_q && sec_tick && alarm_repeat_select_q == 4'h6 && m_s1 && m_s10
      && m_m1 && m_m10 && m_h) |=> alarm_event)
      else $error("daily alarm missed");
  a_weekly_miss: assert property (@(posedge clk) disable iff (!rst_n_q)
      (alarm_enable_q && sec_tick && alarm_repeat_select_q == 4'h7 && !m_wd)
      |=> !alarm_event)
      else $error("weekly alarm fired on wrong weekday");
  a_unused_select: assert property (@(posedge clk) disable iff (!rst_n_q)
      (alarm_enable_q && sec_tick && alarm_repeat_select_q > 4'h9) |=> !alarm_event)
      else $error("reserved select fired");
  a_event_cause: assert property (@(posedge clk) disable iff (!rst_n_q)
      alarm_event |-> $past(match) && $past(tick) && $past(alarm_enable_q))
      else $error("alarm without match");

  // Interrupt status
  a_irq_sticky: assert property (@(posedge clk) disable iff (!rst_n_q)
      alarm_event |=> s_status_to_irq)
      else $error("status not set by alarm");
  a_status_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
      s_read_clear |=> !irq_status_q)
      else $error("status not cleared by read");
  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n_q)
      s_read_and_set |=> irq_status_q)
      else $error("read clear beat a new alarm");

endmodule // rtc_alarm_compare

`default_nettype wire

// ==== rtc_alarm_compare_tb_top.sv ====
// Self-checking bench for the alarm compare block
`timescale 1ns/1ps
`default_nettype none
`include "alarm_regs.svh"

module rtc_alarm_compare_tb_top;
  // ---------------------------------------------------------------------------
  // Signals and table
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] sel;
    logic [2:0] wd;
    logic [7:0] h;
    logic [7:0] m;
    logic [7:0] s;
    logic half;
    logic exp;
  } row_t;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [15:0] reg_rdata;
  alarm_pkg::rtc_time_t now_time = '0;
  logic half_tick = 1'h0;
  logic sec_tick = 1'h0;
  logic alarm_event;
  logic irq;
  logic [15:0] v;
  int bad_count = 0;
  int num_checks = 0;
  // Alarm value is weekday 3, 12:45:27; each row probes one select
  row_t rows [20] = '{
    '{4'h0, 3'h0, 8'h00, 8'h00, 8'h00, 1'h1, 1'h1}, '{4'h0, 3'h0, 8'h00, 8'h00, 8'h00, 1'h0, 1'h0},
    '{4'h1, 3'h0, 8'h00, 8'h00, 8'h00, 1'h0, 1'h1}, '{4'h1, 3'h0, 8'h00, 8'h00, 8'h00, 1'h1, 1'h0},
    '{4'h2, 3'h0, 8'h00, 8'h00, 8'h07, 1'h0, 1'h1}, '{4'h2, 3'h0, 8'h00, 8'h00, 8'h08, 1'h0, 1'h0},
    '{4'h3, 3'h0, 8'h00, 8'h00, 8'h27, 1'h0, 1'h1}, '{4'h3, 3'h0, 8'h00, 8'h00, 8'h17, 1'h0, 1'h0},
    '{4'h4, 3'h0, 8'h00, 8'h05, 8'h27, 1'h0, 1'h1}, '{4'h4, 3'h0, 8'h00, 8'h04, 8'h27, 1'h0, 1'h0},
    '{4'h5, 3'h0, 8'h00, 8'h35, 8'h27, 1'h0, 1'h0}, '{4'h5, 3'h0, 8'h00, 8'h45, 8'h27, 1'h0, 1'h1},
    '{4'h6, 3'h0, 8'h02, 8'h45, 8'h27, 1'h0, 1'h0}, '{4'h6, 3'h0, 8'h12, 8'h45, 8'h27, 1'h0, 1'h1},
    '{4'h7, 3'h2, 8'h12, 8'h45, 8'h27, 1'h0, 1'h0}, '{4'h7, 3'h3, 8'h12, 8'h45, 8'h27, 1'h0, 1'h1},
    '{4'h8, 3'h0, 8'h12, 8'h45, 8'h27, 1'h0, 1'h1}, '{4'h9, 3'h0, 8'h12, 8'h45, 8'h27, 1'h0, 1'h1},
    '{4'hA, 3'h3, 8'h12, 8'h45, 8'h27, 1'h0, 1'h0},
    '{4'h6, 3'h0, 8'h22, 8'h45, 8'h27, 1'h0, 1'h0}};

  always #12.5 clk = ~clk;

  rtc_alarm_compare u_dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .now_time(now_time), .half_tick(half_tick),
    .sec_tick(sec_tick), .alarm_event(alarm_event), .irq(irq));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask

  task automatic tick(input logic half);
    @(posedge clk);
    if (half) half_tick <= 1'h1;
    else sec_tick <= 1'h1;
    @(posedge clk);
    half_tick <= 1'h0;
    sec_tick <= 1'h0;
    #1;
  endtask

  function automatic alarm_pkg::rtc_time_t mk(input row_t r);
    mk = '0;
    mk.weekday = r.wd;
    mk.hour_tens = r.h[5:4];
    mk.hour_ones = r.h[3:0];
    mk.min_tens = r.m[6:4];
    mk.min_ones = r.m[3:0];
    mk.sec_tens = r.s[6:4];
    mk.sec_ones = r.s[3:0];
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    check({reg_rdata[14:0], alarm_event}, 16'h0000, "reset outputs");
    check({15'h0000, irq}, 16'h0000, "reset irq");
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    $display("reset test done");
    // Unused bits read zero whatever is written
    wr(`OFS_ALARM_CTRL, 16'h0010);
    wr(`OFS_ALARM_WEEKDAY_HOURS, 16'hFFFF);
    rd(`OFS_ALARM_WEEKDAY_HOURS, v);
    check(v, 16'h073F, "weekday/hours fields");
    wr(`OFS_ALARM_MINUTES_SECONDS, 16'hFFFF);
    rd(`OFS_ALARM_MINUTES_SECONDS, v);
    check(v, 16'h7F7F, "minutes/seconds fields");
    wr(`OFS_ALARM_WEEKDAY_HOURS, 16'h0312);
    // Locked: weekday/hours keeps its value, minutes/seconds still writable
    wr(`OFS_ALARM_CTRL, 16'h0000);
    wr(`OFS_ALARM_WEEKDAY_HOURS, 16'h0000);
    wr(`OFS_ALARM_MINUTES_SECONDS, 16'h4527);
    rd(`OFS_ALARM_WEEKDAY_HOURS, v);
    check(v, 16'h0312, "locked write");
    rd(`OFS_ALARM_MINUTES_SECONDS, v);
    check(v, 16'h4527, "minutes/seconds value");
    rd(4'hF, v);
    check(v, 16'h0000, "unmapped read");
    $display("register test done");
    // Table of repeat selects, matches and near misses
    foreach (rows[i]) begin
      wr(`OFS_ALARM_CTRL, {12'h003, rows[i].sel});
      now_time <= mk(rows[i]);
      tick(rows[i].half);
      check({15'h0000, alarm_event}, {15'h0000, rows[i].exp}, "row");
    end
    $display("select table done");
    // Interrupt: raise, mask, read-clear
    rd(`OFS_IRQ_STATUS, v);
    wr(`OFS_IRQ_MASK, 16'h0001);
    wr(`OFS_ALARM_CTRL, 16'h0031);
    tick(1'h0);
    check({15'h0000, alarm_event}, 16'h0001, "event for irq");
    @(posedge clk);
    #1 check({15'h0000, irq}, 16'h0001, "irq raised");
    wr(`OFS_IRQ_MASK, 16'h0000);
    #1 check({15'h0000, irq}, 16'h0000, "irq masked");
    rd(`OFS_IRQ_STATUS, v);
    check(v, 16'h0001, "status sticky");
    rd(`OFS_IRQ_STATUS, v);
    check(v, 16'h0000, "status cleared");
    // Alarm disabled: a match must not fire
    wr(`OFS_ALARM_CTRL, 16'h0011);
    tick(1'h0);
    check({15'h0000, alarm_event}, 16'h0000, "disabled alarm");
    $display("interrupt test done");
    // Alarm lands in the cycle of the status read: the set must win
    wr(`OFS_IRQ_MASK, 16'h0001);
    wr(`OFS_ALARM_CTRL, 16'h0031);
    @(posedge clk);
    sec_tick <= 1'h1;
    @(posedge clk);
    sec_tick <= 1'h0;
    reg_addr <= `OFS_IRQ_STATUS;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, 16'h0000, "status before set");
    check({15'h0000, irq}, 16'h0001, "set wins over clear");
    $display("set/clear race test done");
    // Reset in mid-run: outputs drop at once, control and status come back cleared
    @(posedge clk);
    nrst <= 1'h0;
    #1 check(reg_rdata, 16'h0000, "mid-run reset rdata");
    check({15'h0000, alarm_event}, 16'h0000, "mid-run reset event");
    check({15'h0000, irq}, 16'h0000, "mid-run reset irq");
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    rd(`OFS_ALARM_CTRL, v);
    check(v, 16'h0000, "control after reset");
    rd(`OFS_IRQ_STATUS, v);
    check(v, 16'h0000, "status after reset");
    $display("mid-run reset test done");
    test_done();
  end

  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule // rtc_alarm_compare_tb_top
`default_nettype wire
